// *** core/alu_result_if.sv ***
/*
  carries the arithmetic unit's operands and results to the datapath.
  assumes a purely combinational unit on the far side.
*/
`timescale 1ns/100ps
interface alu_result_if;
  import rsd_pkg::*;
  op_type op;
  logic [7:0] operandA;
  logic [7:0] work;
  logic carryIn;
  logic [7:0] result;
  logic carryOut;
  logic digitOut;
  logic zeroOut;
  modport core (output op, operandA, work, carryIn,
    input result, carryOut, digitOut, zeroOut);
  modport unit (input op, operandA, work, carryIn,
    output result, carryOut, digitOut, zeroOut);
endinterface

// *** core/rotate_subtract_datapath.sv ***
/*
  one-cycle datapath for rotate through carry, subtract with borrow and
  auxiliary page read, built around the combinational arithmetic unit.
  assumes fileData carries the contents of fileAddr in the same cycle,
  that the register file takes fileWrite as a one-cycle write strobe and
  that the store into the auxiliary page arrives on auxWrite from outside.
*/
// Functional notes
// - rotate left: bits move up, old carry to bit 0, bit 7 to carry
// - rotate right: bits move down, old carry to bit 7, bit 0 to carry
// - destination bit 0: result to working register, file register kept
// - destination bit 1: result written back to addressed file register
// - file plus inverted working plus carry to destination, sets Z DC C
// - immediate plus inverted working plus carry into working, Z DC C
// - auxiliary read: indexed auxiliary register to working, no flags
`timescale 1ns/100ps
module rotate_subtract_datapath
  import rsd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic opValid,
  input wire op_type opCode,
  input wire logic destSel,
  input wire logic [6:0] fileAddr,
  input wire logic [7:0] fileData,
  input wire logic [7:0] immediate,
  input wire logic [4:0] auxIndex,
  input wire logic auxWrite,
  input wire logic [7:0] auxWriteData,
  output logic [7:0] workReg,
  output logic carryFlag,
  output logic zeroFlag,
  output logic digitFlag,
  output logic fileWrite,
  output logic [6:0] fileWriteAddr,
  output logic [7:0] fileWriteData
);
  alu_result_if alu ();
  logic [7:0] workReg_r;
  logic carry_r;
  logic zero_r;
  logic digit_r;
  logic fileWrite_r;
  logic [6:0] fileWriteAddr_r;
  logic [7:0] fileWriteData_r;
  logic [7:0] auxRegs_r [AUX_COUNT];
  logic [7:0] auxReadData;
  logic isRotLeft;
  logic isRotRight;
  logic isSubReg;
  logic isSubImm;
  logic isAuxRead;
  logic isRotate;
  logic isSub;
  logic toFile;
  logic toWork;

  // plain decode of the one-hot code; opValid low or an idle code does nothing
  always_comb
  begin
    isRotLeft = 1'h0;
    isRotRight = 1'h0;
    isSubReg = 1'h0;
    isSubImm = 1'h0;
    isAuxRead = 1'h0;
    if (opValid)
    begin
      case (opCode)
        OP_ROTATE_LEFT:
        begin
          isRotLeft = 1'h1;
        end
        OP_ROTATE_RIGHT:
        begin
          isRotRight = 1'h1;
        end
        OP_SUB_REGISTER:
        begin
          isSubReg = 1'h1;
        end
        OP_SUB_IMMEDIATE:
        begin
          isSubImm = 1'h1;
        end
        OP_AUX_READ:
        begin
          isAuxRead = 1'h1;
        end
        default:
        begin
          isAuxRead = 1'h0;
        end
      endcase
    end
  end

  assign isRotate = isRotLeft || isRotRight;
  assign isSub = isSubReg || isSubImm;

  // destination select applies to rotates and the register subtract only;
  // the immediate form has no file operand to write back
  assign toFile = (isRotate || isSubReg) && (destSel == DEST_FILE);
  assign toWork = isSubImm
    || ((isRotate || isSubReg) && (destSel == DEST_WORK));

  // operands for the arithmetic unit
  assign alu.op = opValid ? opCode : OP_NONE;
  assign alu.operandA = isSubImm ? immediate : fileData;
  assign alu.work = workReg_r;
  assign alu.carryIn = carry_r;

  rotate_subtract_unit rotate_subtract_unit_inst (
    .bus(alu)
  );

  // one write decode per entry keeps each entry in a process of its own
  genvar g;
  generate
    for (g = 0; g < AUX_COUNT; g++)
    begin : gAux
      logic hit;
      assign hit = auxWrite && (auxIndex == 5'(g));
      always_ff @(posedge sys_clk)
      begin
        if (!nrst)
        begin
          auxRegs_r[g] <= AUX_RESET;
        end
        else if (hit)
        begin
          auxRegs_r[g] <= auxWriteData;
        end
      end
    end
  endgenerate
  assign auxReadData = auxRegs_r[auxIndex];

  // a read of the entry stored in the same cycle returns the old value
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      workReg_r <= WORK_RESET;
    end
    else if (isAuxRead)
    begin
      workReg_r <= auxReadData;
    end
    else if (toWork)
    begin
      workReg_r <= alu.result;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      carry_r <= CARRY_RESET;
    end
    else if (isRotate || isSub)
    begin
      carry_r <= alu.carryOut;
    end
  end

  // rotates touch carry only, so zero and digit wait for a subtract
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      zero_r <= ZERO_RESET;
    end
    else if (isSub)
    begin
      zero_r <= alu.zeroOut;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      digit_r <= DIGIT_RESET;
    end
    else if (isSub)
    begin
      digit_r <= alu.digitOut;
    end
  end

  // the strobe is registered, so the file sees the write one cycle late
  // and must forward it to a back-to-back read of the same address
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      fileWrite_r <= WRITE_STROBE_RESET;
    end
    else
    begin
      fileWrite_r <= toFile;
    end
  end

  // address and data hold between writes
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      fileWriteAddr_r <= WRITE_ADDR_RESET;
    end
    else if (toFile)
    begin
      fileWriteAddr_r <= fileAddr;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      fileWriteData_r <= WRITE_DATA_RESET;
    end
    else if (toFile)
    begin
      fileWriteData_r <= alu.result;
    end
  end

  assign workReg = workReg_r;
  assign carryFlag = carry_r;
  assign zeroFlag = zero_r;
  assign digitFlag = digit_r;
  assign fileWrite = fileWrite_r;
  assign fileWriteAddr = fileWriteAddr_r;
  assign fileWriteData = fileWriteData_r;
endmodule

// *** core/rotate_subtract_unit.sv ***
/*
  combinational rotate and subtract-with-borrow arithmetic.
  assumes operands are stable within the instruction cycle.
*/
`timescale 1ns/100ps
module rotate_subtract_unit
  import rsd_pkg::*;
(
  alu_result_if.unit bus
);
  logic [8:0] sum;
  logic [4:0] lowSum;

  always_comb
  begin
    sum = {1'b0, bus.operandA} + {1'b0, ~bus.work} + {8'h00, bus.carryIn};
    lowSum = {1'b0, bus.operandA[NIBBLE_MSB:0]}
      + {1'b0, ~bus.work[NIBBLE_MSB:0]} + {4'h0, bus.carryIn};
    bus.result = sum[7:0];
    bus.carryOut = sum[8];
    bus.digitOut = lowSum[4];
    case (bus.op)
      OP_ROTATE_LEFT:
      begin
        bus.result = {bus.operandA[6:0], bus.carryIn};
        bus.carryOut = bus.operandA[7];
      end
      OP_ROTATE_RIGHT:
      begin
        bus.result = {bus.carryIn, bus.operandA[7:1]};
        bus.carryOut = bus.operandA[0];
      end
      default:
      begin
        bus.result = sum[7:0];
      end
    endcase
    bus.zeroOut = (bus.result == 8'h00);
  end
endmodule

// *** core/rsd_pkg.sv ***
/*
  shared constants and types for the rotate/subtract datapath.
  assumes an 8-bit core with 128 file registers and 32 auxiliary registers.
*/
package rsd_pkg;
  localparam int DATA_W = 8;
  localparam int FILE_ADDR_W = 7;
  localparam int AUX_ADDR_W = 5;
  localparam int AUX_COUNT = 32;
  localparam int NIBBLE_MSB = 3;
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam logic CARRY_RESET = 1'b0;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic DIGIT_RESET = 1'b0;
  localparam logic WRITE_STROBE_RESET = 1'h0;
  localparam logic [6:0] WRITE_ADDR_RESET = 7'h00;
  localparam logic [7:0] WRITE_DATA_RESET = 8'h00;
  localparam logic DEST_WORK = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  typedef enum logic [5:0] {
    OP_NONE = 6'b000001,
    OP_ROTATE_LEFT = 6'b000010,
    OP_ROTATE_RIGHT = 6'b000100,
    OP_SUB_REGISTER = 6'b001000,
    OP_SUB_IMMEDIATE = 6'b010000,
    OP_AUX_READ = 6'b100000
  } op_type;
endpackage

// *** testbench/rotate_subtract_datapath_assertions.sv ***
/* port assertions for the rotate/subtract datapath.
   assumes a bind into rotate_subtract_datapath; it sees only ports. */
`timescale 1ns/100ps
module rotate_subtract_datapath_assertions
  import rsd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic opValid,
  input wire op_type opCode,
  input wire logic destSel,
  input wire logic [7:0] fileData,
  input wire logic [7:0] immediate,
  input wire logic [7:0] workReg,
  input wire logic carryFlag,
  input wire logic zeroFlag,
  input wire logic digitFlag,
  input wire logic fileWrite
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_rl; opValid && opCode == OP_ROTATE_LEFT; endsequence
  sequence s_rr; opValid && opCode == OP_ROTATE_RIGHT; endsequence
  sequence s_sr; opValid && opCode == OP_SUB_REGISTER; endsequence
  sequence s_si; opValid && opCode == OP_SUB_IMMEDIATE; endsequence
  property p_rl; s_rl |=> carryFlag == $past(fileData[7]); endproperty
  a_rl: assert property (p_rl) else $error("rl carry");
  property p_rr; s_rr |=> carryFlag == $past(fileData[0]); endproperty
  a_rr: assert property (p_rr) else $error("rr carry");
  property p_rw; s_rl ##0 !destSel |=>
    workReg == {$past(fileData[6:0]), $past(carryFlag)}; endproperty
  a_rw: assert property (p_rw) else $error("rl work");
  property p_fw; opValid && (opCode inside {OP_ROTATE_LEFT,
    OP_ROTATE_RIGHT, OP_SUB_REGISTER}) |=> fileWrite == $past(destSel);
  endproperty
  a_fw: assert property (p_fw) else $error("file write");
  property p_kw; s_rr ##0 destSel |=> $stable(workReg); endproperty
  a_kw: assert property (p_kw) else $error("work kept");
  property p_ax; opValid && opCode == OP_AUX_READ |=>
    $stable({carryFlag, zeroFlag, digitFlag}); endproperty
  a_ax: assert property (p_ax) else $error("aux flags");
  property p_sz; s_si |=> zeroFlag == (workReg == 8'h00); endproperty
  a_sz: assert property (p_sz) else $error("sub zero");
  property p_sc; s_si |=> carryFlag == ($past(immediate) +
    9'($past(carryFlag)) > $past(workReg)); endproperty
  a_sc: assert property (p_sc) else $error("sub carry");
  property p_sr; s_sr |=> carryFlag == ($past(fileData) +
    9'($past(carryFlag)) > $past(workReg)); endproperty
  a_sr: assert property (p_sr) else $error("reg sub carry");
  property p_rk; (opValid && (opCode == OP_ROTATE_LEFT ||
    opCode == OP_ROTATE_RIGHT)) |=> $stable({zeroFlag, digitFlag});
  endproperty
  a_rk: assert property (p_rk) else $error("rotate flags");
  property p_sd; s_si |=> digitFlag == (5'($past(immediate[3:0])) +
    5'($past(carryFlag)) > 5'($past(workReg[3:0]))); endproperty
  a_sd: assert property (p_sd) else $error("sub digit");
endmodule
bind rotate_subtract_datapath rotate_subtract_datapath_assertions
  rotate_subtract_datapath_assertions_inst (
  .sys_clk(sys_clk),
  .nrst(nrst),
  .opValid(opValid),
  .opCode(opCode),
  .destSel(destSel),
  .fileData(fileData),
  .immediate(immediate),
  .workReg(workReg),
  .carryFlag(carryFlag),
  .zeroFlag(zeroFlag),
  .digitFlag(digitFlag),
  .fileWrite(fileWrite)
);

// *** testbench/rotate_subtract_datapath_test.sv ***
/* random bench compared with an integer model.
   assumes the datapath and its checker are compiled first. */
`timescale 1ns/100ps
module rotate_subtract_datapath_test;
  import rsd_pkg::*;
  logic sys_clk = 0, nrst = 0, opValid = 0, destSel = 0, auxWrite = 0;
  logic [6:0] fileAddr = 0, fileWriteAddr;
  logic [7:0] fileData = 0, immediate = 0, auxWriteData = 0, workReg;
  logic [7:0] fileWriteData;
  logic [4:0] auxIndex = 0;
  logic carryFlag, zeroFlag, digitFlag, fileWrite;
  op_type opCode = OP_NONE;
  int mismatches = 0, n_checks = 0, w = 0, c = 0, z = 0, d = 0;
  int a, s, r, fw, fa = 0, fd = 0;
  int aux[32] = '{default: 0};
  rotate_subtract_datapath rotate_subtract_datapath_inst (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .opValid(opValid),
    .opCode(opCode),
    .destSel(destSel),
    .fileAddr(fileAddr),
    .fileData(fileData),
    .immediate(immediate),
    .auxIndex(auxIndex),
    .auxWrite(auxWrite),
    .auxWriteData(auxWriteData),
    .workReg(workReg),
    .carryFlag(carryFlag),
    .zeroFlag(zeroFlag),
    .digitFlag(digitFlag),
    .fileWrite(fileWrite),
    .fileWriteAddr(fileWriteAddr),
    .fileWriteData(fileWriteData)
  );
  initial forever #20 sys_clk = ~sys_clk;
  task automatic chk(string n, logic [7:0] v, int e);
    n_checks++;
    if (v !== e[7:0])
    begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", n, e[7:0], v);
    end
  endtask
  task automatic results;
    if (mismatches == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    // reset, 1500 ops and one mid-run reset, with ample margin
    #(2000 * 40);
    mismatches++;
    results;
  end
  initial
  begin
    r = $urandom(32'hc865);
    repeat (8) @(negedge sys_clk);
    nrst = 1;
    for (int i = 0; i < 1500; i++)
    begin
      // a second reset in mid-run must clear everything, aux page too
      if (i == 750)
      begin
        nrst = 0;
        @(negedge sys_clk);
        nrst = 1;
        w = 0;
        c = 0;
        z = 0;
        d = 0;
        fa = 0;
        fd = 0;
        aux = '{default: 0};
      end
      {opValid, destSel, auxWrite} = 3'($urandom);
      opCode = op_type'(6'h01 << ($urandom % 6));
      {fileAddr, fileData, immediate} = 23'($urandom);
      {auxIndex, auxWriteData} = 13'($urandom);
      a = opCode == OP_SUB_IMMEDIATE ? immediate : fileData;
      s = a + (~w & 255) + c;
      fw = 0;
      if (opValid && opCode == OP_AUX_READ)
        w = aux[auxIndex];
      else if (opValid && opCode != OP_NONE)
      begin
        r = opCode == OP_ROTATE_LEFT ? fileData << 1 | c :
          opCode == OP_ROTATE_RIGHT ? fileData >> 1 | c << 7 : s;
        if (opCode == OP_SUB_REGISTER || opCode == OP_SUB_IMMEDIATE)
        begin
          z = (s & 255) == 0;
          d = ((a & 15) + (~w & 15) + c) > 15;
        end
        c = opCode == OP_ROTATE_LEFT ? fileData[7] :
          opCode == OP_ROTATE_RIGHT ? fileData[0] : s > 255;
        fw = destSel && opCode != OP_SUB_IMMEDIATE;
        if (fw)
        begin
          fa = fileAddr;
          fd = r & 255;
        end
        else
          w = r & 255;
      end
      if (auxWrite)
        aux[auxIndex] = auxWriteData;
      @(negedge sys_clk);
      chk("work", workReg, w);
      chk("carry", carryFlag, c);
      chk("zero", zeroFlag, z);
      chk("digit", digitFlag, d);
      chk("fwr", fileWrite, fw);
      chk("fdat", fileWriteData, fd);
      chk("fadr", fileWriteAddr, fa);
    end
    results;
  end
endmodule
